// [src/awq_addr_fifo.sv]
// write-address channel queue with ecc, level flags, counts and wishbone status
`timescale 1ns/1ps
`default_nettype none

module awq_addr_fifo
  import awq_pkg::*;
#(
  parameter int DEPTH = AWQ_DEPTH,
  parameter bit ECC_EN = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire awq_aw_type s_aw,
  input wire logic s_awvalid,
  output logic s_awready,
  output awq_aw_type m_aw,
  output logic m_awvalid,
  input wire logic m_awready,
  input wire logic [$clog2(DEPTH)-1:0] addr_q_low_level_threshold,
  input wire logic [$clog2(DEPTH)-1:0] addr_q_high_level_threshold,
  input wire logic addr_q_corrupt_one_bit_in,
  input wire logic addr_q_corrupt_two_bits_in,
  output logic addr_q_corrected_error_out,
  output logic addr_q_uncorrectable_error_out,
  output logic addr_q_write_rejected,
  output logic addr_q_read_rejected,
  output logic [$clog2(DEPTH)+1:0] addr_q_write_side_occupancy,
  output logic [$clog2(DEPTH)+1:0] addr_q_read_side_occupancy,
  output logic [$clog2(DEPTH)+1:0] addr_q_common_occupancy,
  output logic addr_q_high_level_flag,
  output logic addr_q_low_level_flag,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq
);

  localparam int PTR_W = $clog2(DEPTH); // depth must be a power of two
  localparam int CNT_W = $clog2(DEPTH) + 2; // counts reach DEPTH+1 with output stage
  localparam logic [CNT_W-1:0] MEM_FULL = CNT_W'(DEPTH);

  // hamming encode with overall parity in bit 0
  function automatic logic [AWQ_CW_W-1:0] ecc_encode(input awq_aw_type d);
    logic [AWQ_CW_W-1:0] cw;
    logic [AWQ_PAR_W-1:0] syn;
    int k;
    cw = '0;
    syn = '0;
    k = 0;
    for (int pos = 1; pos < AWQ_CW_W; pos++) begin
      // data goes to every position that is not a power of two
      if ((pos & (pos - 1)) != 0) begin
        cw[pos] = d[k];
        k++;
        if (cw[pos]) begin
          syn = syn ^ AWQ_PAR_W'(pos);
        end
      end
    end
    for (int p = 0; p < AWQ_PAR_W; p++) begin
      cw[1 << p] = syn[p];
    end
    cw[0] = ^cw[AWQ_CW_W-1:1];
    return cw;
  endfunction : ecc_encode

  // decode: returns {corrected, uncorrectable, data}
  function automatic logic [AWQ_PAY_W+1:0] ecc_decode(input logic [AWQ_CW_W-1:0] cw_in, input logic en);
    logic [AWQ_CW_W-1:0] cw;
    logic [AWQ_PAR_W-1:0] syn;
    logic [AWQ_PAY_W-1:0] d;
    logic sb;
    logic db;
    int k;
    cw = cw_in;
    syn = '0;
    d = '0;
    sb = 1'b0;
    db = 1'b0;
    k = 0;
    for (int pos = 1; pos < AWQ_CW_W; pos++) begin
      if (cw[pos]) begin
        syn = syn ^ AWQ_PAR_W'(pos);
      end
    end
    if (en) begin
      if (^cw_in) begin
        // odd parity: one bit wrong, syndrome names it (0 means the parity bit)
        sb = 1'b1;
        if (int'(syn) < AWQ_CW_W) begin
          cw[syn] = ~cw[syn];
        end
      end else if (syn != '0) begin
        // even parity with a syndrome: two bits wrong, cannot repair
        db = 1'b1;
      end
    end
    for (int pos = 1; pos < AWQ_CW_W; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        d[k] = cw[pos];
        k++;
      end
    end
    return {sb, db, d};
  endfunction : ecc_decode

  // storage and pointers
  logic [AWQ_CW_W-1:0] mem_q [DEPTH]; // encoded entries
  logic [PTR_W-1:0] wr_ptr_q; // next slot to write
  logic [PTR_W-1:0] rd_ptr_q; // next slot to read
  logic [CNT_W-1:0] mem_cnt_q; // entries in memory, not counting output stage
  logic [CNT_W-1:0] mem_cnt_d;
  logic [CNT_W-1:0] total_q; // memory plus output stage
  logic [CNT_W-1:0] total_d;
  logic s_ready_q;
  logic m_valid_q;
  awq_aw_type m_aw_q;
  // thresholds captured while reset is held
  logic [PTR_W-1:0] low_thr_q;
  logic [PTR_W-1:0] high_thr_q;
  // status outputs
  logic corr_q;
  logic uncorr_q;
  logic wr_rej_q;
  logic rd_rej_q;
  logic high_q;
  logic low_q;
  // register file
  logic [2:0] ctrl_q;
  awq_evt_type irq_stat_q;
  awq_evt_type irq_mask_q;
  logic irq_q;
  logic [31:0] wb_dat_q;
  logic wb_ack_q;

  // handshakes and derived strobes
  logic push; // entry accepted from upstream
  logic pop; // entry taken by downstream
  logic load; // memory head moves into output stage
  logic wr_refused; // write accepted into a full memory
  logic rd_refused; // load from an empty memory; never set, its last term is zero
  logic inj_one;
  logic inj_two;
  logic dec_en;
  logic [AWQ_CW_W-1:0] wr_cw;
  logic [AWQ_PAY_W+1:0] rd_dec;
  logic wb_req;
  logic wb_wr;
  awq_evt_type evt;

  assign push = s_awvalid && s_ready_q;
  assign pop = m_valid_q && m_awready;
  assign load = (mem_cnt_q != '0) && (!m_valid_q || m_awready);
  // the ready handshake keeps wr_refused low in practice; rd_refused is tied low by its constant zero term
  assign wr_refused = push && (mem_cnt_q == MEM_FULL);
  assign rd_refused = (!m_valid_q || m_awready) && (mem_cnt_q == '0) && 1'b0;
  assign inj_one = ECC_EN && (addr_q_corrupt_one_bit_in || ctrl_q[AWQ_CTRL_INJ_ONE]);
  assign inj_two = ECC_EN && (addr_q_corrupt_two_bits_in || ctrl_q[AWQ_CTRL_INJ_TWO]);
  assign dec_en = ECC_EN && ctrl_q[AWQ_CTRL_DEC_EN];
  assign rd_dec = ecc_decode(mem_q[rd_ptr_q], dec_en);
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  // encoded write word, with optional corruption; double wins over single
  always_comb begin
    wr_cw = ecc_encode(s_aw);
    if (inj_two) begin
      wr_cw[AWQ_INJ_POS_A] = ~wr_cw[AWQ_INJ_POS_A];
      wr_cw[AWQ_INJ_POS_B] = ~wr_cw[AWQ_INJ_POS_B];
    end else if (inj_one) begin
      wr_cw[AWQ_INJ_POS_A] = ~wr_cw[AWQ_INJ_POS_A];
    end
  end

  // next counts; a transfer at this edge is seen only after it
  always_comb begin
    mem_cnt_d = mem_cnt_q + CNT_W'(push) - CNT_W'(load);
    total_d = total_q + CNT_W'(push) - CNT_W'(pop);
  end

  // memory writes; no reset needed, pointers guard stale words
  always_ff @(posedge core_clk) begin
    if (clk_en && push) begin
      mem_q[wr_ptr_q] <= wr_cw;
    end
  end

  // pointers and counts
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      mem_cnt_q <= '0;
      total_q <= '0;
      s_ready_q <= 1'b0;
    end else if (clk_en) begin
      // pointers move on push and load only; a wr_refused write is still a push, so it moves wr_ptr_q and writes memory
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PTR_W'(1);
      end
      if (load) begin
        rd_ptr_q <= rd_ptr_q + PTR_W'(1);
      end
      mem_cnt_q <= mem_cnt_d;
      total_q <= total_d;
      s_ready_q <= mem_cnt_d < MEM_FULL;
    end
  end

  // output stage; errors pulse for the cycle after the word is loaded
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      m_valid_q <= 1'b0;
      m_aw_q <= '0;
      corr_q <= 1'b0;
      uncorr_q <= 1'b0;
    end else if (clk_en) begin
      m_valid_q <= load || (m_valid_q && !m_awready);
      corr_q <= load && rd_dec[AWQ_PAY_W+1];
      uncorr_q <= load && rd_dec[AWQ_PAY_W];
      if (load) begin
        m_aw_q <= awq_aw_type'(rd_dec[AWQ_PAY_W-1:0]);
      end
    end
  end

  // threshold capture: sampled every reset cycle, held afterwards
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      low_thr_q <= addr_q_low_level_threshold;
      high_thr_q <= addr_q_high_level_threshold;
    end
  end

  // level flags and rejection indicators
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      high_q <= 1'b0;
      low_q <= 1'b1;
      wr_rej_q <= 1'b0;
      rd_rej_q <= 1'b0;
    end else if (clk_en) begin
      high_q <= total_d >= CNT_W'(high_thr_q);
      low_q <= total_d <= CNT_W'(low_thr_q);
      wr_rej_q <= wr_refused;
      rd_rej_q <= rd_refused;
    end
  end

  // interrupt events; flag rises use the next-value compares
  always_comb begin
    evt.corr = load && rd_dec[AWQ_PAY_W+1];
    evt.uncorr = load && rd_dec[AWQ_PAY_W];
    evt.write_rej = wr_refused;
    evt.read_rej = rd_refused;
    evt.high_rise = !high_q && (total_d >= CNT_W'(high_thr_q));
    evt.low_rise = !low_q && (total_d <= CNT_W'(low_thr_q));
  end

  // control, mask and sticky status; a new event beats write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_q <= AWQ_CTRL_RST;
      irq_mask_q <= awq_evt_type'(AWQ_MASK_RST);
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (wb_wr && wb_adr_i == AWQ_OFS_CTRL) begin
        ctrl_q <= wb_dat_i[2:0];
      end
      if (wb_wr && wb_adr_i == AWQ_OFS_IRQ_MASK) begin
        irq_mask_q <= awq_evt_type'(wb_dat_i[AWQ_EVT_W-1:0]);
      end
      if (wb_wr && wb_adr_i == AWQ_OFS_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~awq_evt_type'(wb_dat_i[AWQ_EVT_W-1:0])) | evt;
      end else begin
        irq_stat_q <= irq_stat_q | evt;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // wishbone slave: one-cycle ack, unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
    end else if (clk_en) begin
      wb_ack_q <= wb_req;
      wb_dat_q <= '0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          AWQ_OFS_CTRL: begin
            wb_dat_q <= {29'h0000_0000, ctrl_q};
          end
          AWQ_OFS_STATUS: begin
            wb_dat_q[AWQ_ST_CNT_LSB +: CNT_W] <= total_q;
            wb_dat_q[AWQ_ST_HIGH] <= high_q;
            wb_dat_q[AWQ_ST_LOW] <= low_q;
            wb_dat_q[AWQ_ST_READY] <= s_ready_q;
            wb_dat_q[AWQ_ST_VALID] <= m_valid_q;
          end
          AWQ_OFS_IRQ_STAT: begin
            wb_dat_q <= {26'h000_0000, irq_stat_q};
          end
          AWQ_OFS_IRQ_MASK: begin
            wb_dat_q <= {26'h000_0000, irq_mask_q};
          end
          default: begin
            wb_dat_q <= '0;
          end
        endcase
      end
    end
  end

  // every output is a flop; one clock so all three counts agree
  assign s_awready = s_ready_q;
  assign m_awvalid = m_valid_q;
  assign m_aw = m_aw_q;
  assign addr_q_corrected_error_out = corr_q;
  assign addr_q_uncorrectable_error_out = uncorr_q;
  assign addr_q_write_rejected = wr_rej_q;
  assign addr_q_read_rejected = rd_rej_q;
  assign addr_q_write_side_occupancy = total_q;
  assign addr_q_read_side_occupancy = total_q;
  assign addr_q_common_occupancy = total_q;
  assign addr_q_high_level_flag = high_q;
  assign addr_q_low_level_flag = low_q;
  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;
  assign irq = irq_q;

endmodule : awq_addr_fifo

`default_nettype wire

// [src/awq_pkg.sv]
// constants, field layouts and carrier types of the write-address queue
package awq_pkg;
  // storage geometry (documented default depth)
  localparam int AWQ_DEPTH = 16;
  localparam int AWQ_PAY_W = 65; // width of one write-address entry
  localparam int AWQ_PAR_W = 7; // hamming check bits, 2**7 covers 72 positions
  localparam int AWQ_CW_W = AWQ_PAY_W + AWQ_PAR_W + 1; // plus overall parity at bit 0
  // codeword positions flipped by the error injectors (both carry data bits)
  localparam int AWQ_INJ_POS_A = 3;
  localparam int AWQ_INJ_POS_B = 5;
  // register byte offsets
  localparam logic [7:0] AWQ_OFS_CTRL = 8'h00;
  localparam logic [7:0] AWQ_OFS_STATUS = 8'h04;
  localparam logic [7:0] AWQ_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] AWQ_OFS_IRQ_MASK = 8'h0c;
  // control register fields and reset value
  localparam int AWQ_CTRL_DEC_EN = 0; // correction on read
  localparam int AWQ_CTRL_INJ_ONE = 1; // software single-bit injection
  localparam int AWQ_CTRL_INJ_TWO = 2; // software double-bit injection
  localparam logic [2:0] AWQ_CTRL_RST = 3'h1;
  // status register field positions
  localparam int AWQ_ST_CNT_LSB = 0;
  localparam int AWQ_ST_HIGH = 16;
  localparam int AWQ_ST_LOW = 17;
  localparam int AWQ_ST_READY = 18;
  localparam int AWQ_ST_VALID = 19;
  localparam int AWQ_EVT_W = 6;
  localparam logic [AWQ_EVT_W-1:0] AWQ_MASK_RST = 6'h00;

  // one write-address channel transfer
  typedef struct packed {
    logic [3:0] id;
    logic [31:0] addr;
    logic [7:0] len;
    logic [2:0] size;
    logic [1:0] burst;
    logic lock;
    logic [3:0] cache;
    logic [2:0] prot;
    logic [3:0] qos;
    logic [3:0] region;
  } awq_aw_type;

  // interrupt sources, same layout in status and mask
  typedef struct packed {
    logic low_rise;
    logic high_rise;
    logic read_rej;
    logic write_rej;
    logic uncorr;
    logic corr;
  } awq_evt_type;
endpackage : awq_pkg

// [testbench/awq_addr_fifo_asserts.sv]
// concurrent checks on the write-address queue ports
`timescale 1ns/1ps
`default_nettype none
module awq_addr_fifo_asserts
  import awq_pkg::*;
#(
  parameter int DEPTH = AWQ_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic m_awvalid,
  input wire logic m_awready,
  input wire logic [$clog2(DEPTH)-1:0] addr_q_low_level_threshold,
  input wire logic [$clog2(DEPTH)-1:0] addr_q_high_level_threshold,
  input wire logic addr_q_corrected_error_out,
  input wire logic addr_q_uncorrectable_error_out,
  input wire logic addr_q_write_rejected,
  input wire logic addr_q_read_rejected,
  input wire logic [$clog2(DEPTH)+1:0] addr_q_write_side_occupancy,
  input wire logic [$clog2(DEPTH)+1:0] addr_q_read_side_occupancy,
  input wire logic [$clog2(DEPTH)+1:0] addr_q_common_occupancy,
  input wire logic addr_q_high_level_flag,
  input wire logic addr_q_low_level_flag,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  // accepted handshakes; a low clock enable freezes the queue
  logic push;
  logic pop;
  logic [$clog2(DEPTH)+1:0] cnt; // short alias of the common count
  assign push = clk_en && s_awvalid && s_awready;
  assign pop = clk_en && m_awvalid && m_awready;
  assign cnt = addr_q_common_occupancy;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_counts_agree: assert property (cnt == addr_q_write_side_occupancy && cnt == addr_q_read_side_occupancy)
    else $error("occupancy counts disagree");
  a_count_bound: assert property (cnt <= DEPTH + 1)
    else $error("count beyond capacity");
  a_write_step: assert property (push && !pop |=> cnt == $past(cnt) + 1)
    else $error("push not counted on next edge");
  a_read_step: assert property (pop && !push |=> cnt == $past(cnt) - 1)
    else $error("pop not counted on next edge");
  a_full_hold: assert property (clk_en && s_awvalid && !s_awready && !pop |=> $stable(cnt))
    else $error("refused write changed the count");
  a_empty_hold: assert property (clk_en && !m_awvalid && !push |=> $stable(cnt))
    else $error("empty output changed the count");
  a_rejects_low: assert property (!addr_q_write_rejected && !addr_q_read_rejected)
    else $error("rejection indicator raised");
  a_high_flag: assert property ($stable(cnt) |-> addr_q_high_level_flag == (cnt >= addr_q_high_level_threshold))
    else $error("high flag wrong");
  a_low_flag: assert property ($stable(cnt) |-> addr_q_low_level_flag == (cnt <= addr_q_low_level_threshold))
    else $error("low flag wrong");
  a_corr_flag: assert property (addr_q_corrected_error_out |-> m_awvalid && !addr_q_uncorrectable_error_out)
    else $error("corrected pulse without entry");
  a_uncorr_flag: assert property (addr_q_uncorrectable_error_out |-> m_awvalid && !addr_q_corrected_error_out)
    else $error("uncorrectable pulse without entry");
  // reset itself is the antecedent here, so the default disable is overridden
  a_reset_state: assert property (disable iff (1'b0) !reset_n && clk_en |=> cnt == 0 && addr_q_low_level_flag
    && !addr_q_high_level_flag && !addr_q_corrected_error_out && !addr_q_uncorrectable_error_out)
    else $error("reset state wrong");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge late or long");
endmodule : awq_addr_fifo_asserts

bind awq_addr_fifo awq_addr_fifo_asserts #(.DEPTH(DEPTH)) i_chk (.core_clk, .reset_n, .clk_en, .s_awvalid,
  .s_awready, .m_awvalid, .m_awready, .addr_q_low_level_threshold, .addr_q_high_level_threshold,
  .addr_q_corrected_error_out, .addr_q_uncorrectable_error_out, .addr_q_write_rejected, .addr_q_read_rejected,
  .addr_q_write_side_occupancy, .addr_q_read_side_occupancy, .addr_q_common_occupancy, .addr_q_high_level_flag,
  .addr_q_low_level_flag, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// [testbench/awq_addr_fifo_tb.sv]
// self-checking bench for the write-address queue
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module awq_addr_fifo_tb
  import awq_pkg::*;
();
  localparam int DEPTH = 16;
  typedef struct { int n; int c; logic h; logic l; } awq_row_type; // pushes, then count and flags
  // thresholds 2 and 5 put the rows on both flag boundaries
  awq_row_type rows [4] = '{'{2, 2, 1'b0, 1'b1}, '{1, 3, 1'b0, 1'b0}, '{2, 5, 1'b1, 1'b0}, '{12, 17, 1'b1, 1'b0}};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  awq_aw_type s_aw = '0;
  awq_aw_type m_aw;
  logic s_awvalid = 1'b0;
  logic one_in = 1'b0;
  logic two_in = 1'b0;
  logic cyc = 1'b0; // drives cyc and stb together
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic stall = 1'b1; // sink holds off until the drain
  logic clk_en = 1'b1; // dropped once to show that all state freezes
  logic [$clog2(DEPTH)-1:0] low_thr = 4'h2; // thresholds, changed only while reset is held
  logic [$clog2(DEPTH)-1:0] high_thr = 4'h5;
  logic s_awready, m_awvalid, m_awready, ce, ue, wrej, rrej, hi, lo, ack, irq;
  logic [$clog2(DEPTH)+1:0] wcnt, rcnt, cnt;
  logic [31:0] rdat, rd;
  int err_count = 0, tests_run = 0, cycles = 0, pushed = 0, ce_n = 0, ue_n = 0;

  always #12.5 core_clk = ~core_clk;

  // thresholds move only inside a reset, so the queue always loads what it is given
  awq_addr_fifo #(.DEPTH(DEPTH)) i_dut (.core_clk, .reset_n, .clk_en, .s_aw, .s_awvalid, .s_awready, .m_aw,
    .m_awvalid, .m_awready,
    .addr_q_low_level_threshold(low_thr), .addr_q_high_level_threshold(high_thr),
    .addr_q_corrupt_one_bit_in(one_in), .addr_q_corrupt_two_bits_in(two_in), .addr_q_corrected_error_out(ce),
    .addr_q_uncorrectable_error_out(ue), .addr_q_write_rejected(wrej), .addr_q_read_rejected(rrej),
    .addr_q_write_side_occupancy(wcnt), .addr_q_read_side_occupancy(rcnt), .addr_q_common_occupancy(cnt),
    .addr_q_high_level_flag(hi), .addr_q_low_level_flag(lo), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq);
  awq_sink i_sink (.core_clk, .reset_n, .stall, .m_aw, .m_awvalid, .m_awready);

  // entry pattern, distinct per index
  function automatic awq_aw_type mk(input int i);
    awq_aw_type a;
    a = '0;
    a.id = 4'(i);
    a.addr = 32'h1000_0000 + 32'(i);
    a.len = 8'(i);
    return a;
  endfunction : mk

  // error pulses counted and hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (reset_n && ce === 1'b1) ce_n++;
    if (reset_n && ue === 1'b1) ue_n++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // back-to-back pushes; entry 0 gets one flipped bit, entry 1 two
  task automatic push(input int n);
    @(posedge core_clk);
    repeat (n) begin
      s_aw <= mk(pushed);
      s_awvalid <= 1'b1;
      one_in <= (pushed == 0);
      two_in <= (pushed == 1);
      do @(posedge core_clk); while (s_awready !== 1'b1);
      pushed++;
    end
    s_awvalid <= 1'b0;
    one_in <= 1'b0;
    two_in <= 1'b0;
  endtask : push

  // registered outputs need two edges; look between edges
  task automatic settle();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(cnt, 6'h00)
    `CHK({hi, lo, ce, ue, irq}, 5'h08)
    @(posedge core_clk);
    reset_n <= 1'b1;
    $display("test reset done");
    wb(1'b0, AWQ_OFS_CTRL, 32'h0);
    `CHK(rd, 32'(AWQ_CTRL_RST))
    wb(1'b0, AWQ_OFS_IRQ_MASK, 32'h0);
    `CHK(rd, 32'(AWQ_MASK_RST))
    wb(1'b1, 8'h40, 32'hff); // unmapped: ignored
    wb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, AWQ_OFS_STATUS, 32'h0);
    `CHK(rd, (32'h1 << AWQ_ST_LOW) | (32'h1 << AWQ_ST_READY))
    $display("test registers done");
    foreach (rows[i]) begin
      push(rows[i].n);
      settle();
      `CHK(cnt, 6'(rows[i].c))
      `CHK(hi, rows[i].h)
      `CHK(lo, rows[i].l)
    end
    $display("test levels done");
    // full: a held write must be refused without effect
    `CHK(s_awready, 1'b0)
    @(posedge core_clk);
    s_awvalid <= 1'b1;
    repeat (3) @(posedge core_clk);
    s_awvalid <= 1'b0;
    settle();
    `CHK(cnt, 6'h11)
    `CHK(wrej, 1'b0)
    $display("test full done");
    // corrected event and high-flag rise are pending; then mask and clear
    wb(1'b0, AWQ_OFS_IRQ_STAT, 32'h0);
    `CHK(rd, 32'h11)
    wb(1'b1, AWQ_OFS_IRQ_MASK, 32'h1);
    settle();
    `CHK(irq, 1'b1)
    wb(1'b1, AWQ_OFS_IRQ_MASK, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    wb(1'b1, AWQ_OFS_IRQ_STAT, 32'h3f);
    wb(1'b1, AWQ_OFS_IRQ_MASK, 32'h1);
    settle();
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    @(posedge core_clk);
    stall <= 1'b0;
    for (int k = 0; k < 200 && cnt !== 6'h00; k++) @(negedge core_clk);
    settle();
    `CHK(cnt, 6'h00)
    `CHK(lo, 1'b1)
    `CHK(rrej, 1'b0)
    `CHK(ce_n, 1)
    `CHK(ue_n, 1)
    `CHK(i_sink.got.size(), 17)
    foreach (i_sink.got[i]) begin
      if (i != 1) `CHK(i_sink.got[i], mk(i))
    end
    // the uncorrectable load and the low-flag rise both fell in the drain
    wb(1'b0, AWQ_OFS_IRQ_STAT, 32'h0);
    `CHK(rd, 32'h22)
    $display("test drain done");
    // control bits: single injection with correction on, then double with correction off
    wb(1'b1, AWQ_OFS_CTRL, 32'h3);
    push(1);
    wb(1'b1, AWQ_OFS_CTRL, 32'h4);
    push(1);
    wb(1'b1, AWQ_OFS_CTRL, 32'(AWQ_CTRL_RST));
    settle();
    `CHK(ce_n, 2)
    `CHK(ue_n, 1)
    `CHK(irq, 1'b1)
    `CHK(i_sink.got.size(), 19)
    `CHK(i_sink.got[17], mk(17))
    // raw word: codeword bits 3 and 5 carry entry bits 0 and 1
    `CHK(i_sink.got[18], mk(18) ^ awq_aw_type'(65'h3))
    $display("test injection done");
    // a low enable must swallow a held valid without storing anything
    @(posedge core_clk);
    stall <= 1'b1;
    clk_en <= 1'b0;
    s_awvalid <= 1'b1;
    repeat (3) @(posedge core_clk);
    s_awvalid <= 1'b0;
    clk_en <= 1'b1;
    settle();
    `CHK(cnt, 6'h00)
    `CHK(i_sink.got.size(), 19)
    $display("test enable done");
    // second reset clears a non-empty queue and loads new thresholds
    push(2);
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    low_thr <= 4'h0;
    high_thr <= 4'h1;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    `CHK(cnt, 6'h00)
    `CHK({hi, lo}, 2'h1)
    push(1);
    settle();
    `CHK(cnt, 6'h01)
    `CHK({hi, lo}, 2'h2)
    $display("test reload done");
    test_done();
  end
endmodule : awq_addr_fifo_tb
`default_nettype wire

// [testbench/awq_sink.sv]
// downstream write-address slave model with a stall pattern
`timescale 1ns/1ps
`default_nettype none
module awq_sink
  import awq_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire awq_aw_type m_aw,
  input wire logic m_awvalid,
  output logic m_awready
);
  logic [1:0] phase_q; // ready drops one cycle in three, so pops run back to back and stall
  awq_aw_type got[$]; // entries in arrival order
  // ready changes only after an edge; an entry is taken where valid and ready meet
  always @(posedge core_clk) begin
    if (!reset_n) begin
      phase_q <= 2'h0;
      m_awready <= 1'b0;
    end else begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      m_awready <= !stall && (phase_q != 2'h1);
      if (m_awvalid && m_awready) begin
        got.push_back(m_aw);
      end
    end
  end
endmodule : awq_sink
`default_nettype wire
